/* File: pkg/lsml_map.svh */
// constants for the long multiply and single transfer decoder
// Summary of operation
// - act on an instruction only when its condition result is true
// - long multiply touches flags only when its set-flags bit is one
// - multiply two 32-bit operands to a full 64-bit product, signed or unsigned
// - accumulate forms add the high:low pair to the product
// - bit 23 one adds the offset to the base, zero subtracts it
// - offset is a 12-bit immediate or a shifted offset register
// - pre-index uses the modified base as address, post-index the plain base
// - pre-index writes the modified base back only when write-back bit is one
// - post-index always writes the modified base back
// - post-index with write-back bit signals non-privileged mode for that transfer
// - shift field holds immediate amounts only, never a register amount
// - bit 20 one loads from memory, zero stores to memory
// - size bit one moves a byte, zero moves a word
// - lane steering follows the endian select input
// - little-endian byte load picks the addressed lane, zero-extended
// - byte store repeats the low byte in all four lanes
// - little-endian word load rotates the addressed byte into bits 7:0
// - word store drives the register unrotated
// - big-endian byte load picks lanes from 31:24 downward, zero-extended
// - big-endian word load rotates byte to 31:24 at offsets 0/2, 15:8 at 1/3
// - low product half goes to the low register, high half to the high
// - negative flag is bit 63, zero flag set only if all 64 bits are zero
`ifndef LSML_MAP_SVH
`define LSML_MAP_SVH
`define LSML_BIT_IMM   25
`define LSML_BIT_PRE   24
`define LSML_BIT_UP    23
`define LSML_BIT_BYTE  22
`define LSML_BIT_WB    21
`define LSML_BIT_LOAD  20
`define LSML_BIT_SGN   22
`define LSML_BIT_ACC   21
`define LSML_BIT_SET   20
`define LSML_BIT_REGSH 4
`define LSML_MUL_OP    5'h01
`define LSML_MUL_TAG   4'h9
`define LSML_XFER_OP   2'h1
`endif

/* File: pkg/lsml_pkg.sv */
// types shared by the decoder and its lane steering
package lsml_pkg;
  typedef logic [31:0] lsml_word_t;
  typedef enum logic [0:0] {
    LSML_IDLE,
    LSML_WAIT_LOAD
  } lsml_state_e;
endpackage : lsml_pkg

/* File: rtl/lsml_lane_steer.sv */
// load data lane steering for byte and word loads in either endian order
`timescale 1ns/100ps
module lsml_lane_steer (
  input  wire logic              endianBig,
  input  wire logic [1:0]        addrLow,
  input  wire logic              isByte,
  input  wire lsml_pkg::lsml_word_t busData,
  output lsml_pkg::lsml_word_t   loadData
);
  // rotate right by whole bytes
  function automatic lsml_pkg::lsml_word_t rotBytes(input lsml_pkg::lsml_word_t w,
                                                   input logic [1:0] n);
    case (n)
      2'h1:    rotBytes = {w[7:0], w[31:8]};
      2'h2:    rotBytes = {w[15:0], w[31:16]};
      2'h3:    rotBytes = {w[23:0], w[31:24]};
      default: rotBytes = w;
    endcase
  endfunction : rotBytes

  logic [1:0] lane;
  lsml_pkg::lsml_word_t rot;
  lsml_pkg::lsml_word_t laneRot;

  // big-endian counts lanes downward from 31:24
  assign lane = endianBig ? ~addrLow : addrLow;
  // same rotation lands byte in 7:0 (little) or 31:24 / 15:8 (big)
  assign rot = rotBytes(busData, addrLow);
  // a function result cannot be part-selected, so the byte rotation gets its own net
  assign laneRot = rotBytes(busData, lane);
  // byte picks its lane and zero-extends
  always_comb begin
    loadData = rot;
    if (isByte) begin
      loadData = {24'h000000, laneRot[7:0]};
    end
  end
endmodule : lsml_lane_steer

/* File: rtl/lsml_decode.sv */
// long multiply and single data transfer decode and execute block
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "lsml_map.svh"
module lsml_decode (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              instrValid,
  input  wire lsml_pkg::lsml_word_t instr,
  input  wire logic              condMet,
  input  wire logic              privMode,
  input  wire logic              endianSelect,
  input  wire lsml_pkg::lsml_word_t opRm,
  input  wire lsml_pkg::lsml_word_t opRs,
  input  wire lsml_pkg::lsml_word_t opLoBase,
  input  wire lsml_pkg::lsml_word_t opHiSrc,
  input  wire lsml_pkg::lsml_word_t memRdata,
  input  wire logic              memRvalid,
  output logic                   busy,
  output logic [3:0]             idxRm,
  output logic [3:0]             idxRs,
  output logic [3:0]             idxLoBase,
  output logic [3:0]             idxHiSrc,
  output logic                   wrLoEn,
  output logic [3:0]             wrLoIdx,
  output lsml_pkg::lsml_word_t   wrLoData,
  output logic                   wrHiEn,
  output logic [3:0]             wrHiIdx,
  output lsml_pkg::lsml_word_t   wrHiData,
  output logic                   flagWe,
  output logic                   flagN,
  output logic                   flagZ,
  output logic                   flagC,
  output logic                   flagV,
  output logic                   memReq,
  output lsml_pkg::lsml_word_t   memAddr,
  output logic                   memWrite,
  output logic                   memByte,
  output lsml_pkg::lsml_word_t   memWdata,
  output logic                   memUserMode,
  output logic                   illegalShift
);
  // ==========================================================
  // helpers
  // ==========================================================
  // immediate shift of the offset register; amount zero passes unchanged
  function automatic lsml_pkg::lsml_word_t shiftImm(input lsml_pkg::lsml_word_t v,
                                                   input logic [1:0] kind,
                                                   input logic [4:0] amt);
    logic [63:0] twice;
    twice = {v, v};
    case (kind)
      2'h0:    shiftImm = v << amt;
      2'h1:    shiftImm = v >> amt;
      2'h2:    shiftImm = lsml_pkg::lsml_word_t'($signed(v) >>> amt);
      default: shiftImm = lsml_pkg::lsml_word_t'(twice >> amt);
    endcase
  endfunction : shiftImm

  // ==========================================================
  // decode
  // ==========================================================
  lsml_pkg::lsml_state_e state;
  lsml_pkg::lsml_state_e next_state;
  logic                  take;
  logic                  isMul;
  logic                  isXfer;
  logic                  doMul;
  logic                  doXfer;

  // a new instruction is only taken while no load is pending
  assign take   = instrValid && !busy;
  assign isMul  = (instr[27:23] == `LSML_MUL_OP) && (instr[7:4] == `LSML_MUL_TAG);
  assign isXfer = (instr[27:26] == `LSML_XFER_OP);
  // failed condition means no effect at all
  assign doMul  = take && condMet && isMul;
  assign doXfer = take && condMet && isXfer;

  // register file read ports, straight from the instruction fields
  assign idxRm     = instr[3:0];
  assign idxRs     = instr[11:8];
  assign idxLoBase = isMul ? instr[15:12] : instr[19:16];
  assign idxHiSrc  = isMul ? instr[19:16] : instr[15:12];

  // ==========================================================
  // long multiply datapath
  // ==========================================================
  logic        mulSigned;
  logic [63:0] extM;
  logic [63:0] extS;
  logic [63:0] product;
  logic [63:0] accIn;
  logic [63:0] mulResult;

  assign mulSigned = instr[`LSML_BIT_SGN];
  // sign or zero extension makes the low 64 bits of the product exact
  assign extM      = {mulSigned ? {32{opRm[31]}} : 32'h00000000, opRm};
  assign extS      = {mulSigned ? {32{opRs[31]}} : 32'h00000000, opRs};
  assign product   = 64'(extM * extS);
  assign accIn     = instr[`LSML_BIT_ACC] ? {opHiSrc, opLoBase} : 64'h0;
  assign mulResult = product + accIn;

  // ==========================================================
  // single transfer address path
  // ==========================================================
  lsml_pkg::lsml_word_t offset;
  lsml_pkg::lsml_word_t modBase;
  lsml_pkg::lsml_word_t xferAddr;
  logic                 preIdx;
  logic                 writeBack;
  logic                 isLoad;
  logic                 isByte;

  assign preIdx = instr[`LSML_BIT_PRE];
  assign isLoad = instr[`LSML_BIT_LOAD];
  assign isByte = instr[`LSML_BIT_BYTE];

  // immediate is zero-extended, register offset takes an immediate shift
  always_comb begin
    offset = {20'h00000, instr[11:0]};
    if (instr[`LSML_BIT_IMM]) begin
      offset = shiftImm(opRm, instr[6:5], instr[11:7]);
    end
  end

  assign modBase  = instr[`LSML_BIT_UP] ? opLoBase + offset : opLoBase - offset;
  assign xferAddr = preIdx ? modBase : opLoBase;
  // post-index always writes back, pre-index only on request
  assign writeBack = !preIdx || instr[`LSML_BIT_WB];

  // ==========================================================
  // state
  // ==========================================================
  // waiting for load data blocks the next instruction
  always_comb begin
    next_state = state;
    case (state)
      lsml_pkg::LSML_IDLE: begin
        if (doXfer && isLoad) begin
          next_state = lsml_pkg::LSML_WAIT_LOAD;
        end
      end
      lsml_pkg::LSML_WAIT_LOAD: begin
        if (memRvalid) begin
          next_state = lsml_pkg::LSML_IDLE;
        end
      end
      default: next_state = lsml_pkg::LSML_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= lsml_pkg::LSML_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign busy = (state == lsml_pkg::LSML_WAIT_LOAD);

  // ==========================================================
  // memory request
  // ==========================================================
  logic [3:0] loadIdx;
  logic [1:0] loadAddrLow;
  logic       loadByte;

  // address, size and direction leave together as one request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memReq      <= 1'b0;
      memAddr     <= 32'h00000000;
      memWrite    <= 1'b0;
      memByte     <= 1'b0;
      memWdata    <= 32'h00000000;
      memUserMode <= 1'b0;
    end else begin
      memReq <= doXfer;
      if (doXfer) begin
        memAddr  <= xferAddr;
        memWrite <= !isLoad;
        memByte  <= isByte;
        // byte stores fan out to every lane; word stores are never rotated
        memWdata <= isByte ? {4{opHiSrc[7:0]}} : opHiSrc;
        // forced user access lasts only for this request
        memUserMode <= !privMode || (!preIdx && instr[`LSML_BIT_WB]);
      end else begin
        memUserMode <= !privMode;
      end
    end
  end

  // remember where pending load data must go
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loadIdx     <= 4'h0;
      loadAddrLow <= 2'h0;
      loadByte    <= 1'b0;
    end else if (doXfer && isLoad) begin
      loadIdx     <= instr[15:12];
      loadAddrLow <= xferAddr[1:0];
      loadByte    <= isByte;
    end
  end

  // register-amount shifts are never decoded, so no illegal shift is ever flagged
  assign illegalShift = 1'b0;

  // ==========================================================
  // load data return
  // ==========================================================
  lsml_pkg::lsml_word_t steered;

  lsml_lane_steer u_steer (
    .endianBig (endianSelect),
    .addrLow   (loadAddrLow),
    .isByte    (loadByte),
    .busData   (memRdata),
    .loadData  (steered)
  );

  // ==========================================================
  // register write ports
  // ==========================================================
  // low port carries the low product or load data, high port the high
  // product or the updated base; a multiply is never taken while load data is pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrLoEn   <= 1'b0;
      wrLoIdx  <= 4'h0;
      wrLoData <= 32'h00000000;
    end else begin
      wrLoEn <= doMul || (busy && memRvalid);
      if (doMul) begin
        wrLoIdx  <= instr[15:12];
        wrLoData <= mulResult[31:0];
      end else if (busy && memRvalid) begin
        wrLoIdx  <= loadIdx;
        wrLoData <= steered;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrHiEn   <= 1'b0;
      wrHiIdx  <= 4'h0;
      wrHiData <= 32'h00000000;
    end else begin
      wrHiEn <= doMul || (doXfer && writeBack);
      if (doMul) begin
        wrHiIdx  <= instr[19:16];
        wrHiData <= mulResult[63:32];
      end else if (doXfer) begin
        wrHiIdx  <= instr[19:16];
        wrHiData <= modBase;
      end
    end
  end

  // ==========================================================
  // flags
  // ==========================================================
  // carry and overflow carry no meaning here, so they are driven low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flagWe <= 1'b0;
      flagN  <= 1'b0;
      flagZ  <= 1'b0;
      flagC  <= 1'b0;
      flagV  <= 1'b0;
    end else begin
      flagWe <= doMul && instr[`LSML_BIT_SET];
      if (doMul && instr[`LSML_BIT_SET]) begin
        flagN <= mulResult[63];
        flagZ <= (mulResult == 64'h0);
        flagC <= 1'b0;
        flagV <= 1'b0;
      end
    end
  end
endmodule : lsml_decode

/* File: test/lsml_decode_monitor.sv */
// assertion checker for the long multiply and transfer decoder
`timescale 1ns/100ps
module lsml_decode_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instrValid,
  input wire logic [31:0] instr,
  input wire logic        condMet,
  input wire logic        privMode,
  input wire logic [31:0] opRm,
  input wire logic [31:0] opRs,
  input wire logic [31:0] opLoBase,
  input wire logic [31:0] opHiSrc,
  input wire logic        memRvalid,
  input wire logic        busy,
  input wire logic        wrLoEn,
  input wire logic        wrHiEn,
  input wire logic [31:0] wrLoData,
  input wire logic [31:0] wrHiData,
  input wire logic        flagWe,
  input wire logic        flagN,
  input wire logic        flagZ,
  input wire logic        memReq,
  input wire logic [31:0] memAddr,
  input wire logic        memWrite,
  input wire logic        memByte,
  input wire logic [31:0] memWdata,
  input wire logic        memUserMode
);
  // ==========================================
  // decode helpers, immediate offsets only for the address
  logic        take;
  logic        isMul;
  logic        isXfer;
  logic [63:0] prodNow;
  logic [31:0] modBase;
  assign take = instrValid && !busy;
  assign isMul = instr[27:23] == 5'h01 && instr[7:4] == 4'h9;
  assign isXfer = instr[27:26] == 2'h1;
  assign prodNow = {{32{instr[22] & opRm[31]}}, opRm} * {{32{instr[22] & opRs[31]}}, opRs}
                 + (instr[21] ? {opHiSrc, opLoBase} : 64'h0);
  assign modBase = instr[23] ? opLoBase + instr[11:0] : opLoBase - instr[11:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sMul; take && isMul && condMet; endsequence
  sequence sXfer; take && isXfer && condMet; endsequence
  // ==========================================
  // properties
  AST_COND_OFF: assert property (take && !condMet |=> !wrLoEn && !wrHiEn && !memReq && !flagWe)
    else $error("instruction acted on with condition false");
  AST_MUL_RESULT: assert property (sMul |=> wrLoEn && wrHiEn && {wrHiData, wrLoData} == $past(prodNow))
    else $error("long multiply result wrong");
  AST_MUL_FLAGWE: assert property (sMul |=> flagWe == $past(instr[20]))
    else $error("flag write does not follow set-flags bit");
  AST_FLAG_VALUE: assert property (flagWe |-> flagN == wrHiData[31] && flagZ == ({wrHiData, wrLoData} == 64'h0))
    else $error("negative or zero flag wrong");
  AST_XFER_REQ: assert property (sXfer |=> memReq && memWrite == !$past(instr[20]) && memByte == $past(instr[22]))
    else $error("transfer request kind wrong");
  AST_XFER_ADDR: assert property (sXfer ##0 !instr[25] |=> memAddr == ($past(instr[24]) ? $past(modBase) : $past(opLoBase)))
    else $error("transfer address wrong");
  AST_WRITEBACK: assert property (sXfer |=> wrHiEn == (!$past(instr[24]) || $past(instr[21])))
    else $error("base write-back wrong");
  AST_USER_MODE: assert property (sXfer ##0 (privMode && !instr[24] && instr[21]) |=> memUserMode)
    else $error("user mode not forced");
  AST_BYTE_REPL: assert property (memReq && memWrite && memByte |-> memWdata == {4{memWdata[7:0]}})
    else $error("byte store not replicated");
  AST_LOAD_BUSY: assert property (sXfer ##0 instr[20] |=> busy && memReq)
    else $error("load does not wait for data");
  AST_LOAD_DONE: assert property (busy && memRvalid |=> wrLoEn && !busy)
    else $error("load data not returned");
endmodule : lsml_decode_monitor
bind lsml_decode lsml_decode_monitor u_mon (.clk(clk), .rst_n(rst_n), .instrValid(instrValid),
  .instr(instr), .condMet(condMet), .privMode(privMode), .opRm(opRm), .opRs(opRs),
  .opLoBase(opLoBase), .opHiSrc(opHiSrc), .memRvalid(memRvalid), .busy(busy),
  .wrLoEn(wrLoEn), .wrHiEn(wrHiEn), .wrLoData(wrLoData), .wrHiData(wrHiData),
  .flagWe(flagWe), .flagN(flagN), .flagZ(flagZ), .memReq(memReq), .memAddr(memAddr),
  .memWrite(memWrite), .memByte(memByte), .memWdata(memWdata), .memUserMode(memUserMode));

/* File: test/lsml_mem_model.sv */
// memory on the data bus: 16 words, byte lanes, load latency set by the bench
`timescale 1ns/100ps
module lsml_mem_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        endianSelect,
  input wire logic [1:0]  lat,
  input wire logic        memReq,
  input wire logic [31:0] memAddr,
  input wire logic        memWrite,
  input wire logic        memByte,
  input wire logic [31:0] memWdata,
  output logic [31:0]     memRdata,
  output logic            memRvalid
);
  // ==========================================
  // storage and load return
  logic [31:0] mem [16];
  logic [2:0]  cnt;
  logic [3:0]  rdIdx;
  logic [1:0]  ln;
  assign ln = endianSelect ? ~memAddr[1:0] : memAddr[1:0];
  // data toggles while idle so a stale bus never looks valid
  always_ff @(posedge clk) begin
    memRvalid <= cnt == 3'h1;
    memRdata <= (cnt == 3'h1) ? mem[rdIdx] : ~memRdata;
    cnt <= (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
    if (memReq && memWrite && memByte) begin
      mem[memAddr[5:2]][8*ln +: 8] <= memWdata[8*ln +: 8];
    end else if (memReq && memWrite) begin
      mem[memAddr[5:2]] <= memWdata;
    end else if (memReq) begin
      cnt <= {1'b0, lat} + 3'h1;
      rdIdx <= memAddr[5:2];
    end
    if (!rst_n) begin
      cnt <= 3'h0;
      memRvalid <= 1'b0;
      memRdata <= 32'h0f0f3c3c;
    end
  end
endmodule : lsml_mem_model

/* File: test/tb_lsml_decode.sv */
// self-checking bench for the long multiply and transfer decoder
`timescale 1ns/100ps
module tb_lsml_decode;
  // ==========================================
  // signals and bench state
  logic clk, rst_n, instrValid, condMet, privMode, endianSelect, memRvalid, busy;
  logic wrLoEn, wrHiEn, flagWe, flagN, flagZ, memReq, memWrite, memByte, memUserMode;
  logic [3:0] wrLoIdx, wrHiIdx;
  logic [1:0] lat;
  lsml_pkg::lsml_word_t instr, opRm, opRs, opLoBase, opHiSrc, memRdata;
  lsml_pkg::lsml_word_t wrLoData, wrHiData, memAddr, memWdata;
  logic [31:0] shadow [16];
  logic [31:0] r;
  int nFail, totalChecks, cyc, seed;
  lsml_decode dut_u (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
    .condMet(condMet), .privMode(privMode), .endianSelect(endianSelect), .opRm(opRm),
    .opRs(opRs), .opLoBase(opLoBase), .opHiSrc(opHiSrc), .memRdata(memRdata),
    .memRvalid(memRvalid), .busy(busy), .idxRm(), .idxRs(), .idxLoBase(), .idxHiSrc(),
    .wrLoEn(wrLoEn), .wrLoIdx(wrLoIdx), .wrLoData(wrLoData), .wrHiEn(wrHiEn),
    .wrHiIdx(wrHiIdx), .wrHiData(wrHiData), .flagWe(flagWe), .flagN(flagN), .flagZ(flagZ),
    .flagC(), .flagV(), .memReq(memReq), .memAddr(memAddr), .memWrite(memWrite),
    .memByte(memByte), .memWdata(memWdata), .memUserMode(memUserMode), .illegalShift());
  lsml_mem_model mem_u (.clk(clk), .rst_n(rst_n), .endianSelect(endianSelect), .lat(lat),
    .memReq(memReq), .memAddr(memAddr), .memWrite(memWrite), .memByte(memByte),
    .memWdata(memWdata), .memRdata(memRdata), .memRvalid(memRvalid));
  // ==========================================
  // clock and hang guard, sized well past the expected thousand or so cycles
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      wrapUp();
    end
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrapUp
  // lane pick for bytes, rotate right by the byte offset for words
  function automatic logic [31:0] steer(logic [31:0] w, logic [1:0] a, logic b, logic big);
    logic [1:0] ln;
    ln = big ? ~a : a;
    if (b) return {24'h0, w[8*ln +: 8]};
    return (w >> (8 * a)) | (w << (32 - 8 * a));
  endfunction : steer
  // one instruction with its operands, outputs looked at one cycle later
  task automatic issue(logic [31:0] w, a, b, lo, hi, logic cm);
    @(posedge clk);
    {instr, opRm, opRs, opLoBase, opHiSrc, condMet} <= {w, a, b, lo, hi, cm};
    instrValid <= 1'b1;
    @(posedge clk);
    instrValid <= 1'b0;
    @(negedge clk);
  endtask : issue
  // register numbers kept clear of the program counter
  task automatic doMul(logic sg, ac, s, cm, logic [31:0] a, b, lo, hi);
    logic [63:0] e;
    e = {{32{sg & a[31]}}, a} * {{32{sg & b[31]}}, b} + (ac ? {hi, lo} : 64'h0);
    issue({4'he, 5'h01, sg, ac, s, 8'h53, 4'h2, 4'h9, 4'h1}, a, b, lo, hi, cm);
    chk({wrLoEn, flagWe}, {cm, cm & s});
    if (cm) chk({wrHiData, wrLoData, wrHiIdx, wrLoIdx}, {e, 8'h53});
    if (cm & s) chk({flagN, flagZ}, {e[63], e == 64'h0});
  endtask : doMul
  task automatic doXfer(logic p, u, b, w, l, i, cm, logic [31:0] base, off, d);
    logic [31:0] m, ad;
    logic extra;
    m = u ? base + off : base - off;
    ad = p ? m : base;
    extra = 1'b0;
    issue({4'he, 2'h1, i, p, u, b, w, l, 8'h67, i ? 12'h008 : off[11:0]}, off, 0, base, d, cm);
    chk(memReq, cm);
    if (!cm) return;
    chk({memAddr, memWrite, memByte}, {ad, !l, b});
    chk({wrHiEn, memUserMode}, {!p | w, !privMode | (!p & w)});
    if (!p | w) chk({wrHiIdx, wrHiData}, {4'h6, m});
    if (!l) begin
      chk(memWdata, b ? {4{d[7:0]}} : d);
      if (b) shadow[ad[5:2]][8 * (endianSelect ? ~ad[1:0] : ad[1:0]) +: 8] = d[7:0];
      else shadow[ad[5:2]] = d;
      return;
    end
    // a long multiply offered while the load waits must be ignored
    @(posedge clk);
    instr <= 32'he0b53291;
    instrValid <= 1'b1;
    for (int k = 0; k < 12 && !wrLoEn; k++) begin
      @(negedge clk);
      extra |= flagWe;
    end
    instrValid <= 1'b0;
    chk({extra, wrLoEn, wrLoIdx}, {2'h1, 4'h7});
    chk(wrLoData, steer(shadow[ad[5:2]], ad[1:0], b, endianSelect));
  endtask : doXfer
  // ==========================================
  // main sequence: fill memory, multiplies, then random transfers
  initial begin
    {rst_n, instrValid, condMet, privMode, endianSelect, lat} = 7'h0c;
    {instr, opRm, opRs, opLoBase, opHiSrc} = '0;
    seed = 74;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 16; k++) doXfer(1, 1, 0, 0, 0, 0, 1, 4 * k, 0, $random(seed));
    doMul(0, 0, 1, 1, 0, $random(seed), 0, 0);
    doMul(1, 1, 1, 1, 32'h80000000, 32'hffffffff, 32'hffffffff, 32'hffffffff);
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      doMul(r[0], r[1], r[2], r[5:3] != 0, $random(seed), $random(seed), $random(seed), r);
    end
    for (int k = 0; k < 200; k++) begin
      r = $random(seed);
      @(posedge clk);
      {endianSelect, privMode, lat} <= r[11:8];
      doXfer(r[0], r[1], r[2], r[3], r[4], r[5], r[7:6] != 0, 32'h20 + r[20:16],
             k == 0 ? 32'hfff : r[15:12], $random(seed));
    end
    wrapUp();
  end
endmodule : tb_lsml_decode
